/* File: core/claim_defines.svh */
`ifndef CLAIM_DEFINES_SVH
`define CLAIM_DEFINES_SVH

// =====================================================================
// Bus geometry
`define APB_AW 8
`define REG_COUNT 16

// =====================================================================
// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_INSTR 8'h04
`define ADDR_FLAGS 8'h08
`define ADDR_STAT 8'h0c
`define ADDR_EVENT 8'h10
`define ADDR_MASK 8'h14
`define REG_WIN 2'h1

// =====================================================================
// Instruction encodings
`define OP_PROBE_WORD 16'h7b0a
`define OP_RELEASE_WORD 16'h7b09
`define OP_ASSERT_WORD 16'h7b08
`define OP_CLAIM_HI 8'h7b
`define OP_CLAIM_LO 4'hd

// =====================================================================
// Flag positions in the flag register
`define FLG_C 0
`define FLG_Z 1
`define FLG_S 2
`define FLG_V 3
`define FLG_D 4
`define FLG_H 5
`define FLG_W 6

// =====================================================================
// Event bit positions
`define EV_DONE 0
`define EV_TRAP 1
`define EV_GRANT 2
`define EV_BADOP 3
`define EV_BUSY 4
`define EV_W 5

// =====================================================================
// Cycle counts
`define CYC_PROBE 4'h7
`define CYC_PIN 4'h5
`define CYC_HALF 4'h6
`define CYC_DECR 4'h7

`endif

/* File: core/claim_pkg.sv */
package claim_pkg;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_FIXED = 5'h02,
		ST_FIRST = 5'h04,
		ST_DELAY = 5'h08,
		ST_SECOND = 5'h10
	} state_t;

	// Instruction in flight, one-hot
	typedef enum logic [3:0] {
		OP_PROBE = 4'h1,
		OP_RELEASE = 4'h2,
		OP_ASSERT = 4'h4,
		OP_CLAIM = 4'h8
	} op_t;

endpackage

/* File: core/claim_sync.sv */
`timescale 1ns/1ps

// =====================================================================
// Three-stage pin synchroniser; output moves once stages two and three agree
module claim_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);

	logic s1_q; // First stage, read only by s2
	logic s2_q; // Second stage
	logic s3_q; // Third stage

	// Shift chain
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q <= RST_VAL;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				q <= s3_q;
		end
	end

endmodule

/* File: core/claim_unit.sv */
`timescale 1ns/1ps
`include "claim_defines.svh"

// Function
// RULE1: Probe copies grant pin into sign flag
// RULE2: Probe is one fixed word, 7 cycles
// RULE3: Claim clears zero flag before first sample
// RULE4: Grant low first: sign 0, release, stop
// RULE5: Grant high first: drive claim low
// RULE6: Decrement counter register to zero, then resample
// RULE7: Program loads counter above two beforehand
// RULE8: Grant low second: sign 1, claim held
// RULE9: Grant high second: sign 0, release
// RULE10: Request path ends with zero flag set
// RULE11: Sign, zero, claim encode three outcomes
// RULE12: Outside logic blocks bus while claiming
// RULE13: Claim encoding with register field, 12+7n cycles
// RULE14: Release drives claim high, 5 cycles
// RULE15: Assert drives claim low, 5 cycles
// RULE16: Pin instructions trap outside system mode
module claim_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shared_grant_in_n,
	output logic shared_claim_out_n,
	output logic irq
);

	// =================================================================
	// State
	claim_pkg::state_t st_q; // Sequencer state
	claim_pkg::state_t st_d; // Next sequencer state
	claim_pkg::op_t op_q; // Instruction in flight or last run
	logic [3:0] cnt_q; // Cycle countdown within a phase
	logic [3:0] cnt_d; // Next countdown
	logic [3:0] rd_q; // Counter register index
	logic [15:0] regs_q [`REG_COUNT]; // Word register file
	logic [`FLG_W-1:0] flags_q; // H D V S Z C
	logic sys_q; // System mode
	logic [15:0] instr_q; // Last accepted word
	logic [`EV_W-1:0] ev_q; // Sticky events
	logic [`EV_W-1:0] mask_q; // Event mask
	logic claim_n_q; // Claim pin level
	logic irq_q; // Interrupt line
	logic pready_q; // Bus answer
	logic pslverr_q; // Bus error
	logic [31:0] prdata_q; // Bus read data
	logic grant_s; // Synchronised grant pin, 1 = inactive

	// =================================================================
	// Grant pin synchroniser
	claim_sync #(
		.RST_VAL(1'b1)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d(shared_grant_in_n),
		.q(grant_s)
	);

	// =================================================================
	// Bus decode
	wire acc = psel & penable & ~pready_q; // First access cycle
	wire fin = psel & penable & pready_q; // Completing edge
	wire wr_fin = fin & pwrite;
	wire rd_fin = fin & ~pwrite;
	wire aligned = paddr[1:0] == 2'h0;
	wire sel_ctrl = paddr == `ADDR_CTRL;
	wire sel_instr = paddr == `ADDR_INSTR;
	wire sel_flags = paddr == `ADDR_FLAGS;
	wire sel_stat = paddr == `ADDR_STAT;
	wire sel_event = paddr == `ADDR_EVENT;
	wire sel_mask = paddr == `ADDR_MASK;
	wire sel_reg = aligned & (paddr[7:6] == `REG_WIN);
	wire [3:0] reg_idx = paddr[5:2];
	wire mapped = sel_ctrl | sel_instr | sel_flags | sel_stat | sel_event | sel_mask | sel_reg;
	wire busy = st_q != claim_pkg::ST_IDLE;
	// Read selection
	wire [31:0] stat_w = {29'h0000_0000, ~grant_s, ~claim_n_q, busy};
	wire [31:0] rd_mux =
		sel_ctrl ? {31'h0000_0000, sys_q} :
		sel_instr ? {16'h0000, instr_q} :
		sel_flags ? {26'h000_0000, flags_q} :
		sel_stat ? stat_w :
		sel_event ? {27'h000_0000, ev_q} :
		sel_mask ? {27'h000_0000, mask_q} :
		sel_reg ? {16'h0000, regs_q[reg_idx]} : 32'h0000_0000;

	// =================================================================
	// Instruction decode
	wire [15:0] iw = pwdata[15:0];
	wire is_probe = iw == `OP_PROBE_WORD; // [RULE2]
	wire is_rel = iw == `OP_RELEASE_WORD; // [RULE14]
	wire is_set = iw == `OP_ASSERT_WORD; // [RULE15]
	wire is_claim = (iw[15:8] == `OP_CLAIM_HI) & (iw[3:0] == `OP_CLAIM_LO); // [RULE13]
	wire priv = is_probe | is_rel | is_set;
	wire issue_req = wr_fin & sel_instr;
	wire refuse = issue_req & busy;
	wire trap_w = issue_req & ~busy & priv & ~sys_q; // [RULE16]
	wire bad_w = issue_req & ~busy & ~priv & ~is_claim;
	wire issue_w = issue_req & ~busy & ((priv & sys_q) | is_claim);
	// Phase ends
	wire tick = cnt_q == 4'h0;
	wire fixed_end = (st_q == claim_pkg::ST_FIXED) & tick;
	wire first_end = (st_q == claim_pkg::ST_FIRST) & tick;
	wire delay_end = (st_q == claim_pkg::ST_DELAY) & tick;
	wire second_end = (st_q == claim_pkg::ST_SECOND) & tick;
	wire [15:0] dec_val = regs_q[rd_q] - 16'h0001;
	wire last_dec = dec_val == 16'h0000;
	wire done_w = fixed_end | second_end;
	wire granted_w = second_end & ~grant_s;
	wire sw_wr = wr_fin & ~busy; // Control, flag and register-file writes locked while running; mask writes are not
	// Events; a read clears only the bits it returned, so a late set survives
	wire [`EV_W-1:0] ev_set = {refuse, bad_w, granted_w, trap_w, done_w};
	wire [`EV_W-1:0] ev_clr = (rd_fin & sel_event) ? prdata_q[`EV_W-1:0] : {`EV_W{1'b0}};
	wire [`EV_W-1:0] ev_d = (ev_q & ~ev_clr) | ev_set;

	// =================================================================
	// Sequencer next state
	always_comb
	begin
		st_d = st_q;
		cnt_d = tick ? cnt_q : cnt_q - 4'h1;
		unique case (st_q)
			claim_pkg::ST_IDLE:
			begin
				// Launch: claim runs two halves, others one fixed span
				if (issue_w & is_claim)
				begin
					st_d = claim_pkg::ST_FIRST;
					cnt_d = `CYC_HALF - 4'h1; // [RULE13]
				end
				else if (issue_w)
				begin
					st_d = claim_pkg::ST_FIXED;
					cnt_d = is_probe ? `CYC_PROBE - 4'h1 : `CYC_PIN - 4'h1; // [RULE2] [RULE14] [RULE15]
				end
			end
			claim_pkg::ST_FIXED:
			begin
				if (tick)
					st_d = claim_pkg::ST_IDLE;
			end
			claim_pkg::ST_FIRST:
			begin
				// Grant inactive: request and delay; else short tail
				if (tick & grant_s)
				begin
					st_d = claim_pkg::ST_DELAY;
					cnt_d = `CYC_DECR - 4'h1; // [RULE5]
				end
				else if (tick)
				begin
					st_d = claim_pkg::ST_FIXED;
					cnt_d = `CYC_HALF - 4'h1; // [RULE4]
				end
			end
			claim_pkg::ST_DELAY:
			begin
				// One decrement per span until the register is zero
				if (tick & last_dec)
				begin
					st_d = claim_pkg::ST_SECOND;
					cnt_d = `CYC_HALF - 4'h1; // [RULE6]
				end
				else if (tick)
					cnt_d = `CYC_DECR - 4'h1;
			end
			claim_pkg::ST_SECOND:
			begin
				if (tick)
					st_d = claim_pkg::ST_IDLE;
			end
		endcase
	end
	// Sequencer registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= claim_pkg::ST_IDLE;
			cnt_q <= 4'h0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end
	// Operation and operand capture
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_q <= claim_pkg::OP_PROBE;
			rd_q <= 4'h0;
			instr_q <= 16'h0000;
		end
		else if (issue_w)
		begin
			op_q <= is_claim ? claim_pkg::OP_CLAIM :
				is_probe ? claim_pkg::OP_PROBE :
				is_rel ? claim_pkg::OP_RELEASE : claim_pkg::OP_ASSERT;
			rd_q <= iw[7:4];
			instr_q <= iw;
		end
	end

	// =================================================================
	// Flags; C V D H only change by software
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flags_q <= {`FLG_W{1'b0}};
		else if (sw_wr & sel_flags)
			flags_q <= pwdata[`FLG_W-1:0];
		else if (issue_w & is_claim)
			flags_q[`FLG_Z] <= 1'b0; // [RULE3]
		else if (first_end & ~grant_s)
			flags_q[`FLG_S] <= 1'b0; // [RULE4] [RULE11]
		else if (fixed_end & (op_q == claim_pkg::OP_PROBE))
			flags_q[`FLG_S] <= grant_s; // [RULE1]
		else if (second_end)
		begin
			flags_q[`FLG_S] <= ~grant_s; // [RULE8] [RULE9]
			flags_q[`FLG_Z] <= 1'b1; // [RULE10]
		end
	end

	// Claim pin, inactive high from reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			claim_n_q <= 1'b1;
		else if (first_end)
			claim_n_q <= ~grant_s; // [RULE4] [RULE5]
		else if (second_end & grant_s)
			claim_n_q <= 1'b1; // [RULE9]
		else if (fixed_end & (op_q == claim_pkg::OP_RELEASE))
			claim_n_q <= 1'b1; // [RULE14]
		else if (fixed_end & (op_q == claim_pkg::OP_ASSERT))
			claim_n_q <= 1'b0; // [RULE15]
	end

	// Register file; the sequencer owns it while running
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < `REG_COUNT; i++)
				regs_q[i] <= 16'h0000;
		end
		else if (delay_end)
			regs_q[rd_q] <= dec_val; // [RULE6]
		else if (sw_wr & sel_reg)
			regs_q[reg_idx] <= pwdata[15:0];
	end

	// =================================================================
	// Control, events, mask, interrupt
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sys_q <= 1'b0;
			mask_q <= {`EV_W{1'b0}};
			ev_q <= {`EV_W{1'b0}};
			irq_q <= 1'b0;
		end
		else
		begin
			if (sw_wr & sel_ctrl)
				sys_q <= pwdata[0];
			if (wr_fin & sel_mask)
				mask_q <= pwdata[`EV_W-1:0];
			ev_q <= ev_d;
			irq_q <= |(ev_d & mask_q);
		end
	end

	// Bus answer: one wait state, data and error from flops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= acc;
			pslverr_q <= acc & ~mapped;
			prdata_q <= acc ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign shared_claim_out_n = claim_n_q;
	assign irq = irq_q;

	// =================================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_probe_sign;
		(fixed_end && op_q == claim_pkg::OP_PROBE) |=> (flags_q[`FLG_S] == $past(grant_s));
	endproperty
	a_probe_sign: assert property (p_probe_sign) else $error("probe sign wrong"); // [RULE1]
	property p_probe_len;
		(issue_w && is_probe) |=> busy [*7] ##1 !busy;
	endproperty
	a_probe_len: assert property (p_probe_len) else $error("probe length wrong"); // [RULE2]
	property p_claim_zclr;
		(issue_w && is_claim) |=> !flags_q[`FLG_Z] ##6 (st_q != claim_pkg::ST_FIRST);
	endproperty
	a_claim_zclr: assert property (p_claim_zclr) else $error("claim zero flag"); // [RULE3]
	property p_no_req;
		(first_end && !grant_s) |=> claim_n_q && !flags_q[`FLG_S] && !flags_q[`FLG_Z]
			##6 !busy;
	endproperty
	a_no_req: assert property (p_no_req) else $error("no-request path wrong"); // [RULE4]
	property p_req;
		(first_end && grant_s) |=> !claim_n_q && st_q == claim_pkg::ST_DELAY;
	endproperty
	a_req: assert property (p_req) else $error("request not driven"); // [RULE5]
	property p_decr;
		delay_end |=> regs_q[$past(rd_q)] == $past(dec_val);
	endproperty
	a_decr: assert property (p_decr) else $error("decrement wrong"); // [RULE6]
	property p_grant;
		(second_end && !grant_s) |=> flags_q[`FLG_S] && flags_q[`FLG_Z] && !claim_n_q && !busy;
	endproperty
	a_grant: assert property (p_grant) else $error("grant outcome wrong"); // [RULE8]
	property p_nogrant;
		(second_end && grant_s) |=> !flags_q[`FLG_S] && flags_q[`FLG_Z] && claim_n_q;
	endproperty
	a_nogrant: assert property (p_nogrant) else $error("refusal outcome wrong"); // [RULE9]
	property p_release;
		(issue_w && is_rel) |=> busy [*5] ##1 (!busy && claim_n_q && $stable(flags_q));
	endproperty
	a_release: assert property (p_release) else $error("release wrong"); // [RULE14]
	property p_assert;
		(issue_w && is_set) |=> busy [*5] ##1 (!busy && !claim_n_q);
	endproperty
	a_assert: assert property (p_assert) else $error("assert wrong"); // [RULE15]
	property p_trap;
		trap_w |=> $stable(claim_n_q) && $stable(flags_q) && !busy && ev_q[`EV_TRAP];
	endproperty
	a_trap: assert property (p_trap) else $error("trap changed state"); // [RULE16]

	c_granted: cover property (second_end && !grant_s);
	c_refused: cover property (second_end && grant_s);
	c_no_req: cover property (first_end && !grant_s);
	c_trap: cover property (trap_w);

endmodule

/* File: sim/claim_arbiter_model.sv */
`timescale 1ns/1ps

// =====================================================================
// Far-side arbiter: grants a claim after a delay, or holds the resource
module claim_arbiter_model #(
	parameter int GRANT_DLY = 4 // Cycles from claim to grant
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] mode, // 0 never grant, 1 held elsewhere, 2 grant
	input wire logic shared_claim_out_n,
	output logic shared_grant_in_n
);
	int cnt; // Cycles since the claim went active
	logic bus_hold; // Bus requests held off while claim is active

	// Keeps the request timing bounded on the shared bus
	assign bus_hold = ~shared_claim_out_n;

	// Grant pin driver
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			shared_grant_in_n <= 1'b1;
		end
		else if (mode == 2'd1)
			shared_grant_in_n <= 1'b0; // Resource owned by another master
		else if (!bus_hold)
		begin
			cnt <= 0;
			shared_grant_in_n <= 1'b1; // No claim, no grant
		end
		else
		begin
			cnt <= cnt + 1;
			// Grant only in mode 2, after the delay
			shared_grant_in_n <= !(mode == 2'd2 && cnt >= GRANT_DLY);
		end
	end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "claim_defines.svh"

// =====================================================================
// Bench top: APB master, far-side model, scenarios, verdict
module tb_top;
	logic clk; // 20 MHz
	logic rst; // Active high
	logic psel;
	logic penable;
	logic pwrite;
	logic [`APB_AW-1:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic shared_grant_in_n;
	logic shared_claim_out_n;
	logic irq;
	logic [1:0] mode; // Far-side behaviour
	logic [31:0] rdat; // Last read word
	logic rerr; // Last error response
	int num_errors;
	int samples_checked;

	claim_unit i_claim_unit (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .shared_grant_in_n(shared_grant_in_n),
		.shared_claim_out_n(shared_claim_out_n), .irq(irq));

	claim_arbiter_model i_claim_arbiter_model (.clk(clk), .rst(rst), .mode(mode),
		.shared_claim_out_n(shared_claim_out_n), .shared_grant_in_n(shared_grant_in_n));

	// =====================================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk); // Idle cycle keeps back-to-back drives apart
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			chk("apb answer", 32'h0000_0001, 32'h0000_0000);
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rdat & m);
	endtask

	task automatic pchk(input string what, input logic exp);
		chk(what, {31'h0000_0000, exp}, {31'h0000_0000, shared_claim_out_n});
	endtask

	// Pin op; pin keeps old level 4 cycles, new level after cycle 5
	task automatic pin_op(input logic [15:0] op, input logic lvl);
		apb(1'b1, `ADDR_INSTR, {16'h0000, op});
		repeat (4) @(posedge clk);
		@(negedge clk); // Pin looked at mid-cycle, where it is settled
		pchk("pin before op end", ~lvl);
		@(negedge clk);
		pchk("pin after op", lvl);
	endtask

	// =====================================================================
	// Scenarios
	task automatic t_reset;
		rchk("flags reset", `ADDR_FLAGS, 32'h0000_0000, 32'hffff_ffff);
		pchk("pin reset", 1'b1);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rerr});
		$display("test reset done");
	endtask

	// Pin op in normal mode is refused
	task automatic t_trap;
		apb(1'b1, `ADDR_INSTR, {16'h0000, `OP_ASSERT_WORD});
		repeat (8) @(posedge clk);
		pchk("pin after trap", 1'b1);
		rchk("trap event", `ADDR_EVENT, 32'h0000_0002, 32'hffff_ffff);
		apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
		$display("test trap done");
	endtask

	// Probe copies the pin level into sign, other flags kept
	task automatic t_probe(input logic [1:0] m, input logic [31:0] expf);
		mode <= m;
		apb(1'b1, `ADDR_FLAGS, 32'h0000_0039);
		repeat (8) @(posedge clk);
		apb(1'b1, `ADDR_INSTR, {16'h0000, `OP_PROBE_WORD});
		repeat (10) @(posedge clk);
		rchk("probe flags", `ADDR_FLAGS, expf, 32'hffff_fffd);
		$display("test probe done");
	endtask

	// Claim with counter 3: pin level before and at cycle 33, flags, counter
	task automatic t_claim(input logic [1:0] m, input logic mid, input logic fin,
		input logic [31:0] expf, input logic [31:0] expr);
		mode <= m;
		apb(1'b1, 8'h4c, 32'h0000_0003); // Counter above two
		apb(1'b1, `ADDR_FLAGS, 32'h0000_003b);
		repeat (8) @(posedge clk);
		apb(1'b1, `ADDR_INSTR, 32'h0000_7b3d);
		repeat (32) @(posedge clk);
		@(negedge clk); // Pin looked at mid-cycle, where it is settled
		pchk("pin before end", mid);
		@(negedge clk);
		pchk("pin at end", fin);
		rchk("claim flags", `ADDR_FLAGS, expf, 32'hffff_ffff);
		rchk("counter", 8'h4c, expr, 32'hffff_ffff);
		$display("test claim done");
	endtask

	// Done event masked, then unmasked, then cleared by read
	task automatic t_irq;
		apb(1'b0, `ADDR_EVENT, 32'h0000_0000);
		pin_op(`OP_RELEASE_WORD, 1'b1);
		repeat (2) @(posedge clk);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		rchk("done event", `ADDR_EVENT, 32'h0000_0001, 32'hffff_ffff);
		apb(1'b1, `ADDR_MASK, 32'h0000_0001);
		pin_op(`OP_ASSERT_WORD, 1'b0);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
		apb(1'b0, `ADDR_EVENT, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
		pin_op(`OP_RELEASE_WORD, 1'b1);
		$display("test irq done");
	endtask

	// Refusal while busy, status while running, bad opcode, event bits
	task automatic t_busy;
		apb(1'b0, `ADDR_EVENT, 32'h0000_0000);
		apb(1'b1, 8'h4c, 32'h0000_0003); // Counter above two
		apb(1'b1, `ADDR_INSTR, 32'h0000_7b3d);
		apb(1'b1, `ADDR_INSTR, 32'h0000_7b3d);
		repeat (4) @(posedge clk);
		rchk("status running", `ADDR_STAT, 32'h0000_0003, 32'h0000_0007);
		repeat (40) @(posedge clk);
		apb(1'b1, `ADDR_INSTR, 32'h0000_0000);
		rchk("busy events", `ADDR_EVENT, 32'h0000_001d, 32'hffff_ffff);
		$display("test busy done");
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// =====================================================================
	// Clock, watchdog, main sequence
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		#(3000 * 50);
		num_errors++;
		end_of_test;
	end

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		mode = 2'd0;
		num_errors = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_trap;
		t_probe(2'd0, 32'h0000_003d);
		t_probe(2'd1, 32'h0000_0039);
		t_claim(2'd0, 1'b0, 1'b1, 32'h0000_003b, 32'h0000_0000);
		t_claim(2'd1, 1'b1, 1'b1, 32'h0000_0039, 32'h0000_0003);
		t_claim(2'd2, 1'b0, 1'b0, 32'h0000_003f, 32'h0000_0000);
		t_irq;
		t_busy;
		end_of_test;
	end
endmodule
